/* File: rtl/control_interface_pkg.sv */
// Package holding constants and carrier types of the serial command word interface.
package control_interface_pkg;

  localparam int WORD_BITS = 16;
  localparam int WORD_COUNT = 4;
  localparam int FRAME_BITS = 24;
  localparam int ADDR_BITS = 4;
  localparam int WORD_SEL_BITS = 2;
  localparam int MUX_LINE_BITS = 3;
  localparam int ADDR_TOP_BIT = 3;

  localparam int SYS_CLK_PERIOD_PS = 5000;
  localparam int STROBE_WIDTH_NS = 2500;
  localparam int STROBE_WIDTH_CYCLES = (STROBE_WIDTH_NS * 1000 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
  localparam int STROBE_COUNT_BITS = 10;

  localparam int REF_DIVIDE = 4;
  localparam int REF_DIV_BITS = 2;

  localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
  localparam logic [WORD_BITS-1:0] INVERT_MASK_0 = 16'h0000;
  localparam logic [WORD_BITS-1:0] INVERT_MASK_1 = 16'h0000;
  localparam logic [WORD_BITS-1:0] INVERT_MASK_2 = 16'h0000;
  localparam logic [WORD_BITS-1:0] INVERT_MASK_3 = 16'h0000;

  localparam int CAL_WORD = 0;
  localparam int CAL_FIELD_LSB = 0;
  localparam logic [1:0] CAL_MODE_OFF = 2'h0;
  localparam logic [1:0] CAL_MODE_ON = 2'h1;
  localparam logic [1:0] CAL_MODE_AUTO = 2'h2;

  typedef struct packed {
    logic bank_high_enable;
    logic bank_low_enable;
    logic [MUX_LINE_BITS-1:0] line;
  } mux_drive_type;

  typedef struct packed {
    logic cal_switch_a;
    logic cal_switch_b;
    logic reference_out;
  } cal_drive_type;

endpackage

/* File: rtl/sync_stage.sv */
// Two flip-flop synchroniser for a bus of quasi-static or level signals.
`timescale 1ns/1ps
module sync_stage #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] first_reg;
  logic [WIDTH-1:0] second_reg;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_reg <= '0;
      second_reg <= '0;
    end else begin
      first_reg <= async_in;
      second_reg <= first_reg;
    end
  end

  assign sync_out = second_reg;

endmodule

/* File: rtl/command_word_latch.sv */
// One command word latch with per-bit polarity and computer or manual selection.
`timescale 1ns/1ps
module command_word_latch #(
  parameter logic [15:0] INVERT_MASK = 16'h0000
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic word_enable,
  input wire logic [control_interface_pkg::WORD_BITS-1:0] parallel_in,
  input wire logic [control_interface_pkg::WORD_BITS-1:0] panel_in,
  input wire logic manual_mode,
  output logic [control_interface_pkg::WORD_BITS-1:0] latched_word,
  output logic [control_interface_pkg::WORD_BITS-1:0] selected_word
);

  logic [control_interface_pkg::WORD_BITS-1:0] latch_reg;
  logic [control_interface_pkg::WORD_BITS-1:0] latch_next;
  logic [control_interface_pkg::WORD_BITS-1:0] select_reg;
  logic [control_interface_pkg::WORD_BITS-1:0] select_next;

  always_comb begin
    latch_next = latch_reg;
    if (word_enable) begin
      latch_next = parallel_in;
    end
    select_next = manual_mode ? panel_in : (latch_reg ^ INVERT_MASK);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_reg <= control_interface_pkg::WORD_RESET;
      select_reg <= control_interface_pkg::WORD_RESET;
    end else begin
      latch_reg <= latch_next;
      select_reg <= select_next;
    end
  end

  assign latched_word = latch_reg;
  assign selected_word = select_reg;

endmodule

/* File: rtl/serial_command_word_interface.sv */
// Top of the serial command word interface with reference and calibration control.
`timescale 1ns/1ps

// Behaviour
// - Serial control data is inverted before entering the 16-bit shift register.
// - One bit shifts in on each rising edge of the data set shift clock.
// - Of each 24-bit word the last 16 bits stay; earlier bits fall out.
// - Address lines are inverted, routed to monitor multiplexers; top bit disables unselected bank.
// - Address decodes to a one-hot enable for four words, gated by the strobe.
// - The word enable is high as long as the 2.5 us strobe, starting three system clocks after it.
// - Each 16-bit latch always sees the parallel bits; enable low unless addressed.
// - Latch follows while enabled, holds value from falling edge to next enable.
// - Each latched bit is used true or inverted per fixed build mask.
// - Each word selects computer data or panel switches by the mode switch.
// - Mode shows on two indicators and as a status to the monitor system.
// - Reference is internal or external, picked by a grounded or floating pin.
// - Internal oscillator is divided by four into a symmetric square wave.
// - Mode selects local reference in manual, computer reference in computer mode.
// - Calibration on, off or automatic, from panel or computer.
// - Internal or external choice only matters in manual mode.
// - Monitor multiplexers switch statically on the address; data set samples outputs.
// - Both calibration switch outputs follow one common control signal.
module serial_command_word_interface (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic serial_shift_clock,
  input wire logic serial_control_data_n,
  input wire logic word_load_strobe,
  input wire logic [control_interface_pkg::ADDR_BITS-1:0] submux_address_n,
  input wire logic computer_manual_switch,
  input wire logic [control_interface_pkg::WORD_BITS-1:0] panel_switch_0,
  input wire logic [control_interface_pkg::WORD_BITS-1:0] panel_switch_1,
  input wire logic [control_interface_pkg::WORD_BITS-1:0] panel_switch_2,
  input wire logic [control_interface_pkg::WORD_BITS-1:0] panel_switch_3,
  input wire logic ref_source_floating,
  input wire logic internal_osc,
  input wire logic external_reference,
  input wire logic computer_reference,
  output logic [control_interface_pkg::WORD_BITS-1:0] command_word_0,
  output logic [control_interface_pkg::WORD_BITS-1:0] command_word_1,
  output logic [control_interface_pkg::WORD_BITS-1:0] command_word_2,
  output logic [control_interface_pkg::WORD_BITS-1:0] command_word_3,
  output logic [control_interface_pkg::WORD_COUNT-1:0] word_enable,
  output logic [control_interface_pkg::WORD_BITS-1:0] parallel_data,
  output control_interface_pkg::mux_drive_type mux_drive,
  output control_interface_pkg::cal_drive_type cal_drive,
  output logic computer_mode_led,
  output logic manual_mode_led,
  output logic manual_mode_status,
  output logic strobe_short
);

  localparam int WB = control_interface_pkg::WORD_BITS;
  localparam int WC = control_interface_pkg::WORD_COUNT;
  localparam int AB = control_interface_pkg::ADDR_BITS;
  localparam int CB = control_interface_pkg::STROBE_COUNT_BITS;
  localparam logic [CB-1:0] STROBE_LIMIT = CB'(control_interface_pkg::STROBE_WIDTH_CYCLES);
  localparam logic [CB-1:0] STROBE_MAX = '1;

  // Link clock domain: the shift register runs on the data set's clock.
  logic [WB-1:0] shift_reg;
  logic [WB-1:0] shift_next;

  always_comb begin
    shift_next = {shift_reg[WB-2:0], ~serial_control_data_n};
  end

  always_ff @(posedge serial_shift_clock or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg <= control_interface_pkg::WORD_RESET;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // Crossings into the system clock domain.
  logic [WB-1:0] parallel_sync;
  logic strobe_sync;
  logic [AB-1:0] address_sync_n;
  logic manual_sync;
  logic floating_sync;
  logic osc_sync;
  logic ext_ref_sync;
  logic comp_ref_sync;
  logic [4*WB-1:0] panel_sync;

  // The shift register is still while the strobe is high, so its bits are quasi-static there.
  sync_stage #(.WIDTH(WB)) data_sync_inst (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(shift_reg),
    .sync_out(parallel_sync)
  );

  // Strobe, address, mode and reference levels.
  sync_stage #(.WIDTH(AB + 6)) control_sync_inst (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in({word_load_strobe, submux_address_n, computer_manual_switch, ref_source_floating,
               internal_osc, external_reference, computer_reference}),
    .sync_out({strobe_sync, address_sync_n, manual_sync, floating_sync, osc_sync, ext_ref_sync,
               comp_ref_sync})
  );

  // Panel switches are slow levels and need no qualifier.
  sync_stage #(.WIDTH(4 * WB)) panel_sync_inst (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in({panel_switch_3, panel_switch_2, panel_switch_1, panel_switch_0}),
    .sync_out(panel_sync)
  );

  // Strobe edge detection and width check.
  logic strobe_reg;
  logic strobe_next;
  logic [CB-1:0] strobe_count_reg;
  logic [CB-1:0] strobe_count_next;
  logic strobe_short_reg;
  logic strobe_short_next;
  logic [WC-1:0] enable_reg;
  logic [WC-1:0] enable_next;
  logic [AB-1:0] address_true;
  control_interface_pkg::mux_drive_type mux_reg;
  control_interface_pkg::mux_drive_type mux_next;

  always_comb begin
    strobe_next = strobe_sync;
    strobe_count_next = strobe_count_reg;
    strobe_short_next = 1'b0;
    if (strobe_sync && !strobe_reg) begin
      strobe_count_next = CB'(1);
    end else if (strobe_sync && strobe_count_reg != STROBE_MAX) begin
      strobe_count_next = strobe_count_reg + CB'(1);
    end
    if (!strobe_sync && strobe_reg && strobe_count_reg < STROBE_LIMIT) begin
      strobe_short_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_reg <= 1'b0;
      strobe_count_reg <= '0;
      strobe_short_reg <= 1'b0;
    end else begin
      strobe_reg <= strobe_next;
      strobe_count_reg <= strobe_count_next;
      strobe_short_reg <= strobe_short_next;
    end
  end

  // Word enable decode.
  always_comb begin
    address_true = ~address_sync_n;
    enable_next = '0;
    if (strobe_sync) begin
      enable_next[address_true[control_interface_pkg::WORD_SEL_BITS-1:0]] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_reg <= '0;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // Monitor multiplexer drive.
  always_comb begin
    mux_next.line = address_true[control_interface_pkg::MUX_LINE_BITS-1:0];
    mux_next.bank_high_enable = address_true[control_interface_pkg::ADDR_TOP_BIT];
    mux_next.bank_low_enable = ~address_true[control_interface_pkg::ADDR_TOP_BIT];
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mux_reg <= '0;
    end else begin
      mux_reg <= mux_next;
    end
  end

  // The enable is one cycle behind the synchronised strobe, so the data sync has settled.
  logic [WB-1:0] word_sel [WC];

  // Each word takes its fixed polarity mask from the package.
  genvar w;
  generate
    for (w = 0; w < WC; w++) begin : gen_word
      command_word_latch #(
        .INVERT_MASK(w == 0 ? control_interface_pkg::INVERT_MASK_0 :
                      w == 1 ? control_interface_pkg::INVERT_MASK_1 :
                      w == 2 ? control_interface_pkg::INVERT_MASK_2 :
                               control_interface_pkg::INVERT_MASK_3)
      ) latch_inst (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .word_enable(enable_reg[w]),
        .parallel_in(parallel_sync),
        .panel_in(panel_sync[w*WB +: WB]),
        .manual_mode(manual_sync),
        .latched_word(),
        .selected_word(word_sel[w])
      );
    end
  endgenerate

  // Mode indication.
  logic [1:0] mode_led_reg;
  logic [1:0] mode_led_next;

  always_comb begin
    mode_led_next = {manual_sync, ~manual_sync};
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_led_reg <= 2'h0;
    end else begin
      mode_led_reg <= mode_led_next;
    end
  end

  // Divider of the internal oscillator.
  logic osc_prev_reg;
  logic osc_prev_next;
  logic [control_interface_pkg::REF_DIV_BITS-1:0] div_reg;
  logic [control_interface_pkg::REF_DIV_BITS-1:0] div_next;
  logic local_ref;
  logic selected_ref;
  logic [1:0] cal_mode;
  logic cal_level;
  control_interface_pkg::cal_drive_type cal_reg;
  control_interface_pkg::cal_drive_type cal_next;

  always_comb begin
    osc_prev_next = osc_sync;
    div_next = div_reg;
    if (osc_sync && !osc_prev_reg) begin
      div_next = div_reg + control_interface_pkg::REF_DIV_BITS'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_prev_reg <= 1'b0;
      div_reg <= '0;
    end else begin
      osc_prev_reg <= osc_prev_next;
      div_reg <= div_next;
    end
  end

  // Reference selection and calibration gating.
  always_comb begin
    local_ref = floating_sync ? div_reg[control_interface_pkg::REF_DIV_BITS-1] : ext_ref_sync;
    selected_ref = manual_sync ? local_ref : comp_ref_sync;
    cal_mode = word_sel[control_interface_pkg::CAL_WORD][control_interface_pkg::CAL_FIELD_LSB +: 2];
    case (cal_mode)
      control_interface_pkg::CAL_MODE_ON: begin
        cal_level = 1'b1;
      end
      control_interface_pkg::CAL_MODE_AUTO: begin
        cal_level = selected_ref;
      end
      default: begin
        cal_level = 1'b0;
      end
    endcase
    cal_next.reference_out = selected_ref;
    cal_next.cal_switch_a = cal_level;
    cal_next.cal_switch_b = cal_level;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_reg <= '0;
    end else begin
      cal_reg <= cal_next;
    end
  end

  // Outputs.
  assign command_word_0 = word_sel[0];
  assign command_word_1 = word_sel[1];
  assign command_word_2 = word_sel[2];
  assign command_word_3 = word_sel[3];
  assign word_enable = enable_reg;
  assign parallel_data = parallel_sync;
  assign mux_drive = mux_reg;
  assign cal_drive = cal_reg;
  assign computer_mode_led = mode_led_reg[0];
  assign manual_mode_led = mode_led_reg[1];
  assign manual_mode_status = mode_led_reg[1];
  assign strobe_short = strobe_short_reg;

endmodule

/* File: rtl/unused_placeholder_none.sv */
// Intentionally empty companion note file kept out of the build.
`timescale 1ns/1ps

/* File: verif/scwi_assertions.sv */
// Checker watching the ports of the serial command word interface.
`timescale 1ns/1ps
module scwi_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic word_load_strobe,
  input wire logic [3:0] submux_address_n,
  input wire logic computer_manual_switch,
  input wire logic [15:0] panel_switch_1,
  input wire logic computer_reference,
  input wire logic [15:0] command_word_1,
  input wire logic [15:0] command_word_2,
  input wire logic [3:0] word_enable,
  input wire control_interface_pkg::mux_drive_type mux_drive,
  input wire control_interface_pkg::cal_drive_type cal_drive,
  input wire logic computer_mode_led,
  input wire logic manual_mode_led,
  input wire logic manual_mode_status
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_enable_one_hot: assert property ($onehot0(word_enable)) else $error("enable not one hot");
  a_enable_rise: assert property ($rose(word_load_strobe) |-> ##[2:4]
    word_enable == (4'h1 << ~submux_address_n[1:0])) else $error("enable late or wrong");
  a_enable_fall: assert property ($fell(word_load_strobe) |-> ##[2:4] word_enable == 4'h0)
    else $error("enable outlives strobe");
  a_enable_quiet: assert property ((!word_load_strobe)[*4] |-> word_enable == 4'h0) else $error("stray enable");
  a_word_hold: assert property ((!word_enable[2] && !computer_manual_switch && $stable(computer_manual_switch))[*5]
    |-> $stable(command_word_2)) else $error("word changed without enable");
  a_manual_panel: assert property ((computer_manual_switch && $stable(computer_manual_switch)
    && $stable(panel_switch_1))[*5] |-> command_word_1 == panel_switch_1) else $error("panel not selected");
  a_mode_leds: assert property ($stable(computer_manual_switch)[*5] |-> manual_mode_led == computer_manual_switch
    && computer_mode_led == !computer_manual_switch && manual_mode_status == computer_manual_switch)
    else $error("mode indication wrong");
  a_mux_static: assert property ($stable(submux_address_n)[*5] |-> mux_drive ==
    {~submux_address_n[3], submux_address_n[3], ~submux_address_n[2:0]}) else $error("mux drive wrong");
  a_cal_common: assert property (cal_drive.cal_switch_a == cal_drive.cal_switch_b) else $error("cal split");
  a_cpu_reference: assert property ((!computer_manual_switch && $stable(computer_manual_switch)
    && $stable(computer_reference))[*5] |-> cal_drive.reference_out == computer_reference)
    else $error("computer reference not used");
  c_enable_3: cover property ($rose(word_enable[3]));
  c_manual: cover property ($rose(manual_mode_led));
  c_cal_toggle: cover property ($rose(cal_drive.cal_switch_a));
endmodule

bind serial_command_word_interface scwi_checker i_checker (.sys_clk(sys_clk), .reset_n(reset_n),
  .word_load_strobe(word_load_strobe), .submux_address_n(submux_address_n),
  .computer_manual_switch(computer_manual_switch), .panel_switch_1(panel_switch_1),
  .computer_reference(computer_reference), .command_word_1(command_word_1), .command_word_2(command_word_2),
  .word_enable(word_enable), .mux_drive(mux_drive), .cal_drive(cal_drive), .computer_mode_led(computer_mode_led),
  .manual_mode_led(manual_mode_led), .manual_mode_status(manual_mode_status));

/* File: verif/data_set_model.sv */
// Model of the monitor and control data set that feeds the interface.
`timescale 1ns/1ps
module data_set_model (
  input wire logic sys_clk,
  output logic serial_shift_clock,
  output logic serial_control_data_n,
  output logic word_load_strobe,
  output logic [3:0] submux_address_n
);
  initial begin
    serial_shift_clock = 1'b0;
    serial_control_data_n = 1'b1;
    word_load_strobe = 1'b0;
    submux_address_n = 4'hF;
  end
  task automatic set_address(input logic [3:0] true_addr);
    submux_address_n <= ~true_addr;
  endtask
  task automatic strobe_pulse(input int width_ns);
    @(posedge sys_clk);
    #1 word_load_strobe = 1'b1;
    #(width_ns) word_load_strobe = 1'b0;
    #100;
  endtask
  task automatic send_word(input logic [1:0] sel, input logic [23:0] word);
    set_address({2'h0, sel});
    for (int i = 23; i >= 0; i--) begin
      serial_control_data_n = ~word[i];
      #16 serial_shift_clock = 1'b1;
      #16 serial_shift_clock = 1'b0;
    end
    serial_control_data_n = word[0];
    repeat (3) @(posedge sys_clk);
    strobe_pulse(control_interface_pkg::STROBE_WIDTH_NS);
  endtask
endmodule

/* File: verif/serial_command_word_interface_tb.sv */
// Self-checking testbench of the serial command word interface.
`timescale 1ns/1ps
module serial_command_word_interface_tb;
  logic sys_clk = 1'b0, reset_n = 1'b0, manual = 1'b0, floating = 1'b0;
  logic osc = 1'b0, ext_ref = 1'b0, cpu_ref = 1'b0, cled, mled, mstat, sclk, sdat_n, strobe, prev_ref, short_flag;
  logic [15:0] panel [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] last [4] = '{4{control_interface_pkg::WORD_RESET}};
  logic [15:0] cmd [4];
  logic [15:0] par;
  logic [3:0] wen, addr_n;
  logic [23:0] w;
  logic [1:0] m;
  control_interface_pkg::mux_drive_type mux;
  control_interface_pkg::cal_drive_type cal;
  int fail_count = 0, checked = 0, en_cycles = 0, rises, short_count = 0;
  logic [31:0] rng = 32'h00006F13;
  always #2.5 sys_clk = ~sys_clk;
  always #50 osc = ~osc;
  always @(posedge sys_clk) if (wen !== 4'h0) en_cycles++;
  always @(posedge sys_clk) if (short_flag === 1'b1) short_count++;
  data_set_model i_model (.sys_clk(sys_clk), .serial_shift_clock(sclk), .serial_control_data_n(sdat_n),
    .word_load_strobe(strobe), .submux_address_n(addr_n));
  serial_command_word_interface i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .serial_shift_clock(sclk),
    .serial_control_data_n(sdat_n), .word_load_strobe(strobe), .submux_address_n(addr_n),
    .computer_manual_switch(manual), .panel_switch_0(panel[0]), .panel_switch_1(panel[1]),
    .panel_switch_2(panel[2]), .panel_switch_3(panel[3]), .ref_source_floating(floating),
    .internal_osc(osc), .external_reference(ext_ref), .computer_reference(cpu_ref),
    .command_word_0(cmd[0]), .command_word_1(cmd[1]), .command_word_2(cmd[2]), .command_word_3(cmd[3]),
    .word_enable(wen), .parallel_data(par), .mux_drive(mux), .cal_drive(cal), .computer_mode_led(cled),
    .manual_mode_led(mled), .manual_mode_status(mstat), .strobe_short(short_flag));
  function automatic void nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
  endfunction
  function automatic logic [2:0] exp_cal(input logic [1:0] mode, input logic ref_in);
    logic on;
    on = (mode == control_interface_pkg::CAL_MODE_ON) || (mode == control_interface_pkg::CAL_MODE_AUTO && ref_in);
    return {on, on, ref_in};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (exp !== got) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    cyc(5);
    reset_n <= 1'b1;
    cyc(4);
    for (int k = 0; k < 8; k++) begin
      nxt();
      w = (k == 0) ? 24'hFF0000 : (k == 1) ? 24'h00FFFF : rng[23:0];
      en_cycles = 0;
      i_model.send_word(k[1:0], w);
      cyc(8);
      last[k[1:0]] = w[15:0];
      chk("parallel data", {8'h00, w[15:0]}, {8'h00, par});
      chk("enable width", control_interface_pkg::STROBE_WIDTH_CYCLES, en_cycles);
      for (int j = 0; j < 4; j++) chk("command word", last[j], cmd[j]);
    end
    chk("short flag", 24'h000000, short_count);
    en_cycles = 0;
    i_model.strobe_pulse(1000);
    cyc(8);
    chk("short flag", 24'h000001, short_count);
    chk("short enable", 1000 * 1000 / control_interface_pkg::SYS_CLK_PERIOD_PS, en_cycles);
    chk("reloaded word", last[3], cmd[3]);
    @(posedge sys_clk);
    for (int j = 0; j < 4; j++) begin
      nxt();
      panel[j] <= rng[15:0];
    end
    manual <= 1'b1;
    cyc(8);
    for (int j = 0; j < 4; j++) chk("manual word", panel[j], cmd[j]);
    chk("mode leds", 3'h5, {mled, cled, mstat});
    manual <= 1'b0;
    cyc(8);
    for (int j = 0; j < 4; j++) chk("computer word", last[j], cmd[j]);
    chk("mode leds", 3'h2, {mled, cled, mstat});
    for (int v = 0; v < 16; v++) begin
      i_model.set_address(v[3:0]);
      cyc(8);
      chk("mux drive", {v[3], ~v[3], v[2:0]}, mux);
    end
    manual <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      m = k[2:1];
      panel[0] <= {14'h0000, m};
      ext_ref <= k[0];
      cyc(8);
      chk("manual cal", exp_cal(m, k[0]), cal);
    end
    manual <= 1'b0;
    floating <= 1'b1;
    i_model.send_word(2'h0, 24'h000002);
    for (int k = 0; k < 4; k++) begin
      cpu_ref <= k[0];
      cyc(8);
      chk("computer cal", exp_cal(control_interface_pkg::CAL_MODE_AUTO, k[0]), cal);
    end
    manual <= 1'b1;
    panel[0] <= {14'h0000, control_interface_pkg::CAL_MODE_OFF};
    cyc(10);
    rises = 0;
    for (int k = 0; k < 640; k++) begin
      prev_ref = cal.reference_out;
      @(posedge sys_clk);
      if (!prev_ref && cal.reference_out) rises++;
    end
    chk("divided oscillator", 24'h000008, rises);
    tally_and_finish();
  end
endmodule
